// ### sfmaf_regs.svh
// Constants of the FIFO control block: sizes, resource register indices, reset values and counts.
`ifndef SFMAF_REGS_SVH
`define SFMAF_REGS_SVH

`define SFMAF_WIDTH        18
`define SFMAF_DEPTH        512
`define SFMAF_AW           9
`define SFMAF_CW           10
`define SFMAF_STAGE_DEPTH  8
`define SFMAF_OFS_AE       2'h0
`define SFMAF_OFS_AF       2'h1
`define SFMAF_OFS_CMD      2'h2
`define SFMAF_AE_RST       18'h0003F
`define SFMAF_AF_RST       18'h0003F
`define SFMAF_CMD_RST      18'h00000
`define SFMAF_CMD_ENH      18'h00FC0
`define SFMAF_HALF_CNT     10'h101
`define SFMAF_FULL_CNT     10'h200
`define SFMAF_LAST_ADDR    9'h1FF
`define SFMAF_START_CAP    2'h2
`define SFMAF_START_DONE   2'h3

`endif

// ### sfmaf_pkg.sv
// Types shared by the FIFO control block.
package sfmaf_pkg;

    typedef enum logic [5:0] {
        MODE_STANDALONE  = 6'b000001,
        MODE_RETRANSMIT  = 6'b000010,
        MODE_MASTER      = 6'b000100,
        MODE_SLAVE       = 6'b001000,
        MODE_INTERLOCK   = 6'b010000,
        MODE_RESERVED    = 6'b100000
    } sfmaf_mode_type;

    typedef enum logic [2:0] {
        RSEL_AE  = 3'b001,
        RSEL_AF  = 3'b010,
        RSEL_CMD = 3'b100
    } sfmaf_rsel_type;

endpackage

// ### sfmaf_fifo.sv
// Small staging FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module sfmaf_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_in,
    input  wire logic             nrst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_idx;
    logic [AW-1:0]    rd_idx;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Full and empty come straight from the count, so the filling side really stalls.
    assign in_ready_out  = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = store[rd_idx];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            store[wr_idx] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + AW'(1);
            end
            if (pop) begin
                rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### sfmaf_ctrl.sv
// Control of an 18-bit FIFO: grouping mode, resource registers, storage and status flags.
//
// Behaviour
// - Enhanced pin low at reset: interlocked paralleled.
// - Both chain inputs high: cascaded slave/master.
// - Both chain inputs low: standalone with retransmit.
// - Load low, write enabled: write resource register.
// - Load low, both disabled: step write selector.
// - Load low, read enabled: output resource register.
// - Load low, both disabled: step read selector.
// - Load high: write word on enabled write edge.
// - Load high: read word on enabled read edge.
// - Two independent resource selection machines.
// - Reset puts both selectors at word zero.
// - Selectors cycle offsets then command, repeating.
// - Empty at zero, almost empty up to n.
// - Almost full from depth minus m; full.
// - Half full low from 257 words; cascaded: one-cycle low as a word lands in the last address.
// - Full blocks writes.
// - Empty blocks reads, output holds.
// - Interlocked mode ANDs second enables in.
// - Reset clears pointers, loads default offsets.
`timescale 1ns/10ps
`include "sfmaf_regs.svh"
module sfmaf_ctrl (
    input  wire logic                    sys_clk_in,
    input  wire logic                    nrst_in,
    input  wire logic [`SFMAF_WIDTH-1:0] data_in,
    input  wire logic                    write_clock_in,
    input  wire logic                    read_clock_in,
    input  wire logic                    write_enable_n_in,
    input  wire logic                    read_enable_n_in,
    input  wire logic                    load_select_n_in,
    input  wire logic                    enhanced_select_n_in,
    input  wire logic                    write_chain_in,
    input  wire logic                    read_chain_in,
    input  wire logic                    first_load_in,
    output logic [`SFMAF_WIDTH-1:0]      data_out,
    output logic                         full_flag_n_out,
    output logic                         almost_full_flag_n_out,
    output logic                         half_full_flag_n_out,
    output logic                         almost_empty_flag_n_out,
    output logic                         empty_flag_n_out,
    output sfmaf_pkg::sfmaf_mode_type    mode_out
);
    import sfmaf_pkg::*;

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    // Every pin is asynchronous to sys_clk_in. Data and controls pass the same
    // two stages as the clock pins so they line up with the detected edges.
    localparam int NSYNC = 9;
    logic [NSYNC-1:0]        pin_s1;
    logic [NSYNC-1:0]        pin_s2;
    logic [`SFMAF_WIDTH-1:0] data_s1;
    logic [`SFMAF_WIDTH-1:0] data_s2;
    logic                    wclk_s3;
    logic                    rclk_s3;
    logic                    first_load_s3;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_s1  <= 9'h01C;
            pin_s2  <= 9'h01C;
            data_s1 <= '0;
            data_s2 <= '0;
            wclk_s3 <= 1'b0;
            rclk_s3 <= 1'b0;
            first_load_s3 <= 1'b0;
        end else begin
            pin_s1  <= {first_load_in, read_chain_in, write_chain_in, enhanced_select_n_in,
                        load_select_n_in, read_enable_n_in, write_enable_n_in,
                        read_clock_in, write_clock_in};
            pin_s2  <= pin_s1;
            data_s1 <= data_in;
            data_s2 <= data_s1;
            wclk_s3 <= pin_s2[0];
            rclk_s3 <= pin_s2[1];
            first_load_s3 <= pin_s2[8];
        end
    end

    logic wclk_rise;
    logic rclk_rise;
    logic wen_n;
    logic ren_n;
    logic load_n;
    logic em_n;
    logic chain_w;
    logic chain_r;
    logic first_load;

    assign wclk_rise = pin_s2[0] && !wclk_s3;
    assign rclk_rise = pin_s2[1] && !rclk_s3;
    assign wen_n     = pin_s2[2];
    assign ren_n     = pin_s2[3];
    assign load_n     = pin_s2[4];
    assign em_n       = pin_s2[5];
    assign chain_w    = pin_s2[6];
    assign chain_r    = pin_s2[7];
    assign first_load = pin_s2[8];

    // --------------------------------------------------------------
    // Grouping mode capture
    // --------------------------------------------------------------
    // The straps are caught once the synchronisers have refilled after the
    // reset release; nothing is accepted until then.
    logic [1:0]     start_cnt;
    logic           ready;
    sfmaf_mode_type mode;
    sfmaf_mode_type next_mode;

    always_comb begin
        if (!em_n) begin
            next_mode = MODE_INTERLOCK;
        end else if (chain_w && chain_r) begin
            next_mode = first_load ? MODE_SLAVE : MODE_MASTER;
        end else if (!chain_w && !chain_r) begin
            next_mode = first_load ? MODE_RETRANSMIT : MODE_STANDALONE;
        end else begin
            next_mode = MODE_RESERVED;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            start_cnt <= 2'h0;
            mode      <= MODE_STANDALONE;
        end else if (start_cnt != `SFMAF_START_DONE) begin
            start_cnt <= start_cnt + 2'h1;
            if (start_cnt == `SFMAF_START_CAP) begin
                mode <= next_mode;
            end
        end
    end

    assign ready    = (start_cnt == `SFMAF_START_DONE);
    assign mode_out = mode;

    // --------------------------------------------------------------
    // Operation decode
    // --------------------------------------------------------------
    logic both_edges;
    logic wr_en;
    logic rd_en;
    logic res_wr;
    logic res_wstep;
    logic res_rd;
    logic res_rstep;
    logic fifo_wr_req;
    logic fifo_rd_req;
    logic retransmit_pulse;
    logic half_flag_mode;

    // Simultaneous edges with load low are illegal; the block then does nothing.
    assign both_edges  = wclk_rise && rclk_rise && !load_n;
    assign wr_en       = !wen_n && ((mode != MODE_INTERLOCK) || chain_w);
    assign rd_en       = !ren_n && ((mode != MODE_INTERLOCK) || chain_r);
    assign res_wr      = ready && !load_n && wclk_rise && !both_edges && wr_en;
    assign res_wstep   = ready && !load_n && wclk_rise && !both_edges && wen_n && ren_n;
    assign res_rd      = ready && !load_n && rclk_rise && !both_edges
                       && wen_n && rd_en;
    assign res_rstep   = ready && !load_n && rclk_rise && !both_edges && wen_n && ren_n;
    assign fifo_wr_req = ready && load_n && wclk_rise && wr_en;
    assign fifo_rd_req = ready && load_n && rclk_rise && rd_en;
    assign half_flag_mode   = (mode != MODE_MASTER) && (mode != MODE_SLAVE);
    assign retransmit_pulse = ready && half_flag_mode && first_load && !first_load_s3;

    // --------------------------------------------------------------
    // Resource registers and their two selectors
    // --------------------------------------------------------------
    sfmaf_rsel_type          wsel;
    sfmaf_rsel_type          rsel;
    logic [`SFMAF_WIDTH-1:0] ae_off;
    logic [`SFMAF_WIDTH-1:0] af_off;
    logic [`SFMAF_WIDTH-1:0] cmd_reg;
    logic [`SFMAF_WIDTH-1:0] rsel_val;

    // The write and read selectors step on their own edges only.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wsel <= RSEL_AE;
        end else if (res_wr || res_wstep) begin
            unique case (wsel)
                RSEL_AE:  wsel <= RSEL_AF;
                RSEL_AF:  wsel <= RSEL_CMD;
                RSEL_CMD: wsel <= RSEL_AE;
                default:  wsel <= RSEL_AE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rsel <= RSEL_AE;
        end else if (res_rd || res_rstep) begin
            unique case (rsel)
                RSEL_AE:  rsel <= RSEL_AF;
                RSEL_AF:  rsel <= RSEL_CMD;
                RSEL_CMD: rsel <= RSEL_AE;
                default:  rsel <= RSEL_AE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ae_off  <= `SFMAF_AE_RST;
            af_off  <= `SFMAF_AF_RST;
            cmd_reg <= `SFMAF_CMD_RST;
        end else if (start_cnt == `SFMAF_START_CAP) begin
            cmd_reg <= em_n ? `SFMAF_CMD_RST : `SFMAF_CMD_ENH;
        end else if (res_wr) begin
            unique case (wsel)
                RSEL_AE:  ae_off  <= data_s2;
                RSEL_AF:  af_off  <= data_s2;
                RSEL_CMD: cmd_reg <= data_s2;
                default:  cmd_reg <= cmd_reg;
            endcase
        end
    end

    always_comb begin
        unique case (rsel)
            RSEL_AE:  rsel_val = ae_off;
            RSEL_AF:  rsel_val = af_off;
            RSEL_CMD: rsel_val = cmd_reg;
            default:  rsel_val = '0;
        endcase
    end

    // --------------------------------------------------------------
    // Staging buffer and storage array
    // --------------------------------------------------------------
    // Written words queue in the staging buffer and drain into the array one
    // per cycle; a write is refused while the buffer has no room.
    logic [`SFMAF_CW-1:0]    total;
    logic [`SFMAF_CW-1:0]    mcount;
    logic [`SFMAF_CW-1:0]    next_total;
    logic [`SFMAF_CW-1:0]    next_mcount;
    logic [`SFMAF_AW-1:0]    wr_ptr;
    logic [`SFMAF_AW-1:0]    rd_ptr;
    logic [`SFMAF_WIDTH-1:0] mem [`SFMAF_DEPTH];
    logic                    stg_ready;
    logic                    stg_valid;
    logic [`SFMAF_WIDTH-1:0] stg_data;
    logic                    drain;
    logic                    wr_ok;
    logic                    rd_ok;
    logic                    chain_pulse;

    assign wr_ok = fifo_wr_req && stg_ready && (total != `SFMAF_FULL_CNT);
    assign rd_ok = fifo_rd_req && (mcount != '0) && !retransmit_pulse;
    assign drain = stg_valid && (mcount != `SFMAF_FULL_CNT);

    sfmaf_fifo #(
        .WIDTH (`SFMAF_WIDTH),
        .DEPTH (`SFMAF_STAGE_DEPTH)
    ) u_stage (
        .sys_clk_in    (sys_clk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (wr_ok),
        .in_ready_out  (stg_ready),
        .in_data_in    (data_s2),
        .out_valid_out (stg_valid),
        .out_ready_in  (mcount != `SFMAF_FULL_CNT),
        .out_data_out  (stg_data)
    );

    always_ff @(posedge sys_clk_in) begin
        if (drain) begin
            mem[wr_ptr] <= stg_data;
        end
    end

    assign next_total  = total + `SFMAF_CW'(wr_ok) - `SFMAF_CW'(rd_ok);
    // Retransmit replays from the first location; it is only meaningful before
    // the write pointer has wrapped, so a user must retransmit before that.
    assign next_mcount = retransmit_pulse ? `SFMAF_CW'(wr_ptr) + `SFMAF_CW'(drain)
                                  : mcount + `SFMAF_CW'(drain) - `SFMAF_CW'(rd_ok);

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            total  <= '0;
            mcount <= '0;
        end else begin
            if (drain) begin
                wr_ptr <= wr_ptr + `SFMAF_AW'(1);
            end
            if (retransmit_pulse) begin
                rd_ptr <= '0;
            end else if (rd_ok) begin
                rd_ptr <= rd_ptr + `SFMAF_AW'(1);
            end
            total  <= retransmit_pulse ? next_mcount + (next_total - mcount) - `SFMAF_CW'(drain) : next_total;
            mcount <= next_mcount;
        end
    end

    // --------------------------------------------------------------
    // Data output and flags
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_out <= '0;
        end else if (res_rd) begin
            data_out <= rsel_val;
        end else if (rd_ok) begin
            data_out <= mem[rd_ptr];
        end
    end

    assign chain_pulse = drain && (wr_ptr == `SFMAF_LAST_ADDR);

    // Flags other than the cascaded half flag are built from the next counts so they are registered yet current.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            full_flag_n_out         <= 1'b1;
            almost_full_flag_n_out  <= 1'b1;
            half_full_flag_n_out    <= 1'b1;
            almost_empty_flag_n_out <= 1'b0;
            empty_flag_n_out        <= 1'b0;
        end else begin
            full_flag_n_out         <= (next_total != `SFMAF_FULL_CNT);
            almost_full_flag_n_out  <= ({9'h000, next_total} + {1'b0, af_off}) < 19'h00200;
            half_full_flag_n_out    <= half_flag_mode ? (next_total < `SFMAF_HALF_CNT) : !chain_pulse;
            almost_empty_flag_n_out <= ({8'h00, next_total} > ae_off);
            empty_flag_n_out        <= (next_mcount != '0);
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    full_blocks_a: assert property (!full_flag_n_out |=> total <= $past(total))
        else $error("count grew while full");
    empty_holds_a: assert property (!empty_flag_n_out && load_n |=> $stable(data_out))
        else $error("output changed while empty");
    sel_reset_a: assert property (!ready |-> (wsel == RSEL_AE) && (rsel == RSEL_AE))
        else $error("selectors not at word zero after reset");
    wsel_cycle_a: assert property ((res_wr || res_wstep) |=>
        (3'(wsel) == {$past(wsel[1:0]), $past(wsel[2])}))
        else $error("write selector did not step in order");
    rsel_indep_a: assert property (!(res_rd || res_rstep) |=> $stable(rsel))
        else $error("read selector moved without a read-side edge");
    res_write_a: assert property (res_wr && (wsel == RSEL_AF) |=> af_off == $past(data_s2))
        else $error("resource write lost");
    res_read_a: assert property (res_rd |=> data_out == $past(rsel_val))
        else $error("resource read wrong");
    fifo_write_a: assert property (wr_ok && !rd_ok && !retransmit_pulse |=> total == $past(total) + 10'h001)
        else $error("write not counted");
    half_flag_a: assert property (half_flag_mode && $stable(total) ##1 $stable(total)
        |-> half_full_flag_n_out == (total < 10'h101))
        else $error("half flag wrong");
    ae_flag_a: assert property ($stable(total) ##1 $stable(total) && $stable(ae_off)
        |-> almost_empty_flag_n_out == ({8'h00, total} > ae_off))
        else $error("almost empty flag wrong");
    illegal_pair_a: assert property (both_edges |=> $stable(wsel) && $stable(rsel))
        else $error("selector moved on illegal edge pair");

    fill_full_c: cover property (!full_flag_n_out);
    res_write_c: cover property (res_wr && (wsel == RSEL_CMD));
    retransmit_c: cover property (retransmit_pulse);
    interlock_c: cover property ((mode == MODE_INTERLOCK) && wr_ok);
endmodule

// ### sfmaf_host.sv
// Model of the writing and reading system logic that drives the FIFO pins.
`timescale 1ns/10ps
module sfmaf_host (
    input  wire logic   sys_clk_in,
    output logic [17:0] data_out,
    output logic        wclk_out,
    output logic        rclk_out,
    output logic        wen_n_out,
    output logic        ren_n_out,
    output logic        load_n_out,
    output logic        enh_n_out,
    output logic        wchain_out,
    output logic        rchain_out,
    output logic        first_load_out
);
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    initial begin
        {data_out, wclk_out, rclk_out} = '0;
        {wen_n_out, ren_n_out, load_n_out, enh_n_out} = 4'hF;
        {wchain_out, rchain_out, first_load_out} = 3'h0;
    end

    // Any strap pattern is driven as given; mixed chain pairs are not filtered out.
    task automatic straps(input logic [3:0] s);
        @(posedge sys_clk_in);
        {enh_n_out, wchain_out, rchain_out, first_load_out} <= s;
    endtask

    // Controls settle a cycle before the clock rises, so the synchronisers never split them.
    task automatic pulse(input logic wr, input logic load_n, input logic wen_n, input logic ren_n,
                         input logic [17:0] d);
        @(posedge sys_clk_in);
        {load_n_out, wen_n_out, ren_n_out, data_out} <= {load_n, wen_n, ren_n, d};
        @(posedge sys_clk_in);
        if (wr) begin
            wclk_out <= 1'b1;
        end else begin
            rclk_out <= 1'b1;
        end
        repeat (3) @(posedge sys_clk_in);
        {wclk_out, rclk_out} <= 2'h0;
        repeat (3) @(posedge sys_clk_in);
        data_out <= ~d;
        #1;
    endtask
endmodule

// ### tb.sv
// Self-checking testbench of the FIFO control block.
`timescale 1ns/10ps
module tb;
    import sfmaf_pkg::*;
    // ------------------------------------------------------------
    // Signals, clock and instances
    // ------------------------------------------------------------
    logic           sys_clk_in = 1'b0;
    logic           nrst_in;
    logic [17:0]    data_in;
    logic [17:0]    data_out;
    logic           wclk, rclk, wen_n, ren_n, load_n, enh_n, wchain, rchain, first_load;
    wire  [4:0]     flags;
    sfmaf_mode_type mode;
    int             err_total = 0;
    int             tests_run = 0;
    int             cyc = 0;

    always #12.5 sys_clk_in = ~sys_clk_in;

    sfmaf_host u_host (.sys_clk_in(sys_clk_in), .data_out(data_in), .wclk_out(wclk), .rclk_out(rclk),
        .wen_n_out(wen_n), .ren_n_out(ren_n), .load_n_out(load_n), .enh_n_out(enh_n),
        .wchain_out(wchain), .rchain_out(rchain), .first_load_out(first_load));

    sfmaf_ctrl u_dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .data_in(data_in),
        .write_clock_in(wclk), .read_clock_in(rclk), .write_enable_n_in(wen_n),
        .read_enable_n_in(ren_n), .load_select_n_in(load_n), .enhanced_select_n_in(enh_n),
        .write_chain_in(wchain), .read_chain_in(rchain), .first_load_in(first_load), .data_out(data_out),
        .full_flag_n_out(flags[4]), .almost_full_flag_n_out(flags[3]), .half_full_flag_n_out(flags[2]),
        .almost_empty_flag_n_out(flags[1]), .empty_flag_n_out(flags[0]), .mode_out(mode));

    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    // Flags are {full, almost full, half full, almost empty, empty}, all active low, default offsets.
    function automatic logic [17:0] fexp(input int n);
        return {13'h0000, n != 512, n < 449, n < 257, n > 63, n != 0};
    endfunction

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [3:0] s);
        u_host.straps(s);
        nrst_in <= 1'b0;
        repeat (5) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
    endtask

    task automatic test_modes();
        logic [3:0]     st [5];
        sfmaf_mode_type em [5];
        st = '{4'h8, 4'h9, 4'hE, 4'hF, 4'h5};
        em = '{MODE_STANDALONE, MODE_RETRANSMIT, MODE_MASTER, MODE_SLAVE, MODE_INTERLOCK};
        for (int k = 0; k < 5; k++) begin
            do_reset(st[k]);
            chk("mode", {12'h000, em[k]}, {12'h000, mode});
        end
    endtask

    task automatic test_resource();
        logic [17:0] rv [3];
        rv = '{18'h0003F, 18'h0003F, 18'h00000};
        do_reset(4'h8);
        for (int k = 0; k < 3; k++) begin
            u_host.pulse(1'b0, 1'b0, 1'b1, 1'b0, 18'h00000);
            chk("reg reset", rv[k], data_out);
        end
        u_host.pulse(1'b0, 1'b0, 1'b1, 1'b1, 18'h00000);
        chk("read step", 18'h00000, data_out);
        u_host.pulse(1'b1, 1'b0, 1'b1, 1'b1, 18'h00000);
        for (int k = 0; k < 3; k++) begin
            u_host.pulse(1'b1, 1'b0, 1'b0, 1'b1, 18'h00011 * 18'(k + 1));
        end
        // Both selectors sit on word one here, each reached by four steps.
        for (int k = 0; k < 3; k++) begin
            u_host.pulse(1'b0, 1'b0, 1'b1, 1'b0, 18'h00000);
            chk("reg data", 18'h00011 * 18'(k + 1), data_out);
        end
    endtask

    task automatic test_fifo();
        do_reset(4'h8);
        chk("flags", fexp(0), 18'(flags));
        for (int i = 1; i <= 513; i++) begin
            u_host.pulse(1'b1, 1'b1, 1'b0, 1'b1, 18'(i));
            chk("flags", fexp(i > 512 ? 512 : i), 18'(flags));
        end
        for (int i = 1; i <= 513; i++) begin
            u_host.pulse(1'b0, 1'b1, 1'b1, 1'b0, 18'h00000);
            chk("read data", 18'(i > 512 ? 512 : i), data_out);
            chk("flags", fexp(i > 512 ? 0 : 512 - i), 18'(flags));
        end
    endtask

    task automatic test_interlock();
        do_reset(4'h0);
        u_host.pulse(1'b1, 1'b1, 1'b0, 1'b1, 18'h15555);
        chk("flags", fexp(0), 18'(flags));
        u_host.straps(4'h6);
        u_host.pulse(1'b1, 1'b1, 1'b1, 1'b1, 18'h0AAAA);
        chk("flags", fexp(0), 18'(flags));
        u_host.pulse(1'b1, 1'b1, 1'b0, 1'b1, 18'h15555);
        chk("flags", fexp(1), 18'(flags));
        u_host.straps(4'h4);
        u_host.pulse(1'b0, 1'b1, 1'b1, 1'b0, 18'h00000);
        chk("read data", 18'h00000, data_out);
        u_host.straps(4'h6);
        u_host.pulse(1'b0, 1'b1, 1'b1, 1'b1, 18'h00000);
        chk("read data", 18'h00000, data_out);
        u_host.pulse(1'b0, 1'b1, 1'b1, 1'b0, 18'h00000);
        chk("read data", 18'h15555, data_out);
        chk("flags", fexp(0), 18'(flags));
    endtask

    // A short high level on the first-load pin replays the stored words from the start.
    task automatic test_retransmit();
        do_reset(4'h8);
        u_host.pulse(1'b1, 1'b1, 1'b0, 1'b1, 18'h01234);
        u_host.pulse(1'b1, 1'b1, 1'b0, 1'b1, 18'h05678);
        u_host.pulse(1'b0, 1'b1, 1'b1, 1'b0, 18'h00000);
        chk("read data", 18'h01234, data_out);
        u_host.straps(4'h9);
        u_host.straps(4'h8);
        u_host.pulse(1'b0, 1'b1, 1'b1, 1'b0, 18'h00000);
        chk("replay data", 18'h01234, data_out);
        chk("flags", fexp(1), 18'(flags));
    endtask

    // A hang is cut short well above the roughly 8500 cycles the run needs.
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 32'h00009C40) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        nrst_in = 1'b0;
        repeat (5) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        test_modes();
        test_resource();
        test_fifo();
        test_interlock();
        test_retransmit();
        tally_and_finish();
    end
endmodule
